/* rtl/bes_pkg.sv */
// Package: constants for the regulator enable and soft-start controller
package bes_pkg;
   // Build options
   localparam logic [7:0] BES_OPT_00 = 8'h00;
   localparam logic [7:0] BES_OPT_01 = 8'h01;
   localparam logic [7:0] BES_OPT_03 = 8'h03;
   localparam logic [7:0] BES_OPT_04 = 8'h04;
   localparam logic [7:0] BES_OPT_05 = 8'h05;
   localparam logic [7:0] BES_OPT_08 = 8'h08;
   localparam logic [7:0] BES_OPT_09 = 8'h09;
   localparam logic [7:0] BES_OPT_23 = 8'h23;
   localparam logic [7:0] BES_OPT_24 = 8'h24;
   localparam logic [7:0] BES_OPT_042 = 8'h42;
   // Register map (word addressed)
   localparam int BES_AW = 4;
   localparam logic [3:0] BES_ADDR_SET_A = 4'h0;
   localparam logic [3:0] BES_ADDR_SET_B = 4'h1;
   localparam logic [3:0] BES_ADDR_CTRL = 4'h2;
   localparam logic [3:0] BES_ADDR_STAT = 4'h3;
   // Voltage setting layout: [7] sw enable, [6] pfm disable, [5:0] level
   localparam int BES_SET_EN_BIT = 7;
   localparam int BES_SET_MODE_BIT = 6;
   localparam int BES_LVL_W = 6;
   localparam logic [5:0] BES_LVL_A_RST = 6'h2D;
   localparam logic [5:0] BES_LVL_B_RST = 6'h3C;
   // Control layout: [7] output discharge
   localparam int BES_CTRL_DIS_BIT = 7;
   localparam logic [7:0] BES_CTRL_RST = 8'h80;
   // Retry timing
   localparam int BES_CL_LIMIT = 16;
   localparam longint BES_CLK_HZ = 100000000;
   localparam longint BES_RETRY_MS = 1700;
   localparam longint BES_RETRY_CYC = BES_RETRY_MS * BES_CLK_HZ / 1000;
   // Soft-start ramp: one reference step per this many cycles
   localparam logic [7:0] BES_SS_STEP_CYC = 8'h10;
   localparam int BES_REF_W = 8;
   localparam logic [7:0] BES_REF_MAX = 8'hFF;
   typedef enum logic [1:0] {BES_OFF, BES_SOFT, BES_RUN, BES_RETRY} bes_state_t;
endpackage

/* rtl/bes_ctrl.sv */
// Enable, soft-start and current-limit retry control of a step-down regulator
// Function
// - Enable pin low holds everything shut down
// - Enable pin low: no register reads/writes
// - Enable low keeps registers, some builds reset
// - Power-on reset restores every default
// - Discharge when bit set and output disabled
// - Enable rise with sw enable starts soft-start
// - Soft-start ramps the reference gradually
// - Synchronous rectification inhibited during soft-start
// - Sixteen current-limit cycles: tri-state, wait, retry
// - Output follows sw enable picked by select
// - Listed builds reset both enables high
// - Builds 01, 05 reset enables to 10
// - Build 03 forces internal select low
// - Mode bit high disables pulse-frequency mode
// - Select low picks setting A, high B
`timescale 1ns/1ps
`default_nettype none
module bes_ctrl
   import bes_pkg::*;
#(
   parameter logic [7:0] BUILD_OPT = BES_OPT_00,
   parameter longint RETRY_CYC = BES_RETRY_CYC
)
(
   input wire logic clk_i,
   input wire logic rstn_i,
   input wire logic enable_pin_i,
   input wire logic voltage_select_pin_i,
   input wire logic sw_cycle_i,
   input wire logic current_limit_i,
   input wire logic [3:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [7:0] rdata_o,
   output logic active_o,
   output logic stage_tristate_o,
   output logic sync_rect_en_o,
   output logic pfm_disable_o,
   output logic discharge_o,
   output logic [7:0] ref_o,
   output logic [5:0] target_level_o
);

   // ----------------------------------------------------------------
   // Build-dependent defaults
   // ----------------------------------------------------------------
   localparam logic EN_B_RST = !(BUILD_OPT == BES_OPT_01 || BUILD_OPT == BES_OPT_05);
   localparam logic RESET_ON_LOW = (BUILD_OPT == BES_OPT_04 || BUILD_OPT == BES_OPT_24 ||
                                    BUILD_OPT == BES_OPT_042);
   localparam logic SEL_TIED_LOW = (BUILD_OPT == BES_OPT_03);
   localparam logic [7:0] SET_A_RST = {1'b1, 1'b0, BES_LVL_A_RST};
   localparam logic [7:0] SET_B_RST = {EN_B_RST, 1'b0, BES_LVL_B_RST};
   localparam int RCW = $clog2(RETRY_CYC + 1);

   // ----------------------------------------------------------------
   // Pin synchronisers (three stages, change once last two agree)
   // ----------------------------------------------------------------
   logic [2:0] en_sync;
   logic [2:0] sel_sync;
   logic [2:0] cyc_sync;
   logic [2:0] cl_sync;
   logic en_q;
   logic sel_q;
   logic cyc_q;
   logic cl_q;
   logic cyc_prev;

   always_ff @(posedge clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         en_sync <= 3'h0;
         sel_sync <= 3'h0;
         cyc_sync <= 3'h0;
         cl_sync <= 3'h0;
      end
      else
      begin
         en_sync <= {en_sync[1:0], enable_pin_i};
         sel_sync <= {sel_sync[1:0], voltage_select_pin_i};
         cyc_sync <= {cyc_sync[1:0], sw_cycle_i};
         cl_sync <= {cl_sync[1:0], current_limit_i};
      end
   end

   // Filtered levels: only stages two and three are compared
   always_ff @(posedge clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         en_q <= 1'b0;
         sel_q <= 1'b0;
         cyc_q <= 1'b0;
         cl_q <= 1'b0;
         cyc_prev <= 1'b0;
      end
      else
      begin
         if (en_sync[1] == en_sync[2])
            en_q <= en_sync[2];
         if (sel_sync[1] == sel_sync[2])
            sel_q <= sel_sync[2];
         if (cyc_sync[1] == cyc_sync[2])
            cyc_q <= cyc_sync[2];
         if (cl_sync[1] == cl_sync[2])
            cl_q <= cl_sync[2];
         cyc_prev <= cyc_q;
      end
   end

   logic en_prev;
   always_ff @(posedge clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
         en_prev <= 1'b0;
      else
         en_prev <= en_q;
   end

   logic sel_int;
   logic cyc_end;
   logic en_rise;
   assign sel_int = SEL_TIED_LOW ? 1'b0 : sel_q;
   assign cyc_end = cyc_prev && !cyc_q; // Falling edge closes one switching cycle
   assign en_rise = en_q && !en_prev;

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   logic [7:0] set_a;
   logic [7:0] set_b;
   logic [7:0] ctrl;
   logic [7:0] sel_set;
   logic sw_en_sel;
   assign sel_set = sel_int ? set_b : set_a;
   assign sw_en_sel = sel_set[BES_SET_EN_BIT];

   // Writes only with the enable pin high; asynchronous reset is power-on
   always_ff @(posedge clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         set_a <= SET_A_RST;
         set_b <= SET_B_RST;
         ctrl <= BES_CTRL_RST;
      end
      else if (!en_q && RESET_ON_LOW)
      begin
         set_a <= SET_A_RST;
         set_b <= SET_B_RST;
         ctrl <= BES_CTRL_RST;
      end
      else if (wr_i && en_q)
      begin
         if (addr_i == BES_ADDR_SET_A)
            set_a <= wdata_i;
         if (addr_i == BES_ADDR_SET_B)
            set_b <= wdata_i;
         if (addr_i == BES_ADDR_CTRL)
            ctrl <= wdata_i;
      end
   end

   // ----------------------------------------------------------------
   // Sequencer
   // ----------------------------------------------------------------
   bes_state_t state;
   logic [4:0] cl_cnt;
   logic [RCW-1:0] retry_cnt;
   logic [7:0] step_cnt;
   logic [7:0] ref_lvl;
   logic want_on;
   assign want_on = en_q && sw_en_sel;

   // Main state machine; the fault wait overrides software until it ends
   always_ff @(posedge clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
         state <= BES_OFF;
      else
      begin
         case (state)
            BES_OFF:
               if (want_on && (en_rise || en_prev))
                  state <= BES_SOFT;
            BES_SOFT:
               if (!want_on)
                  state <= BES_OFF;
               else if (cl_cnt == 5'(BES_CL_LIMIT))
                  state <= BES_RETRY;
               else if (ref_lvl == BES_REF_MAX)
                  state <= BES_RUN;
            BES_RUN:
               if (!want_on)
                  state <= BES_OFF;
               else if (cl_cnt == 5'(BES_CL_LIMIT))
                  state <= BES_RETRY;
            BES_RETRY:
               if (!en_q)
                  state <= BES_OFF;
               else if (retry_cnt == RCW'(RETRY_CYC - 1))
                  state <= want_on ? BES_SOFT : BES_OFF;
            default:
               state <= BES_OFF;
         endcase
      end
   end

   // Consecutive current-limit cycle counter
   always_ff @(posedge clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
         cl_cnt <= 5'h00;
      else if (state != BES_SOFT && state != BES_RUN)
         cl_cnt <= 5'h00;
      else if (cyc_end)
         cl_cnt <= cl_q ? cl_cnt + 5'h01 : 5'h00;
   end

   // Off-time counter; only runs in the wait state
   always_ff @(posedge clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
         retry_cnt <= '0;
      else if (state == BES_RETRY)
         retry_cnt <= retry_cnt + RCW'(1);
      else
         retry_cnt <= '0;
   end

   // Reference ramp: stepping avoids inrush and overshoot
   always_ff @(posedge clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         ref_lvl <= 8'h00;
         step_cnt <= 8'h00;
      end
      else if (state == BES_SOFT)
      begin
         if (step_cnt == BES_SS_STEP_CYC - 8'h01)
         begin
            step_cnt <= 8'h00;
            if (ref_lvl != BES_REF_MAX)
               ref_lvl <= ref_lvl + 8'h01;
         end
         else
            step_cnt <= step_cnt + 8'h01;
      end
      else if (state != BES_RUN)
      begin
         ref_lvl <= 8'h00;
         step_cnt <= 8'h00;
      end
   end

   // ----------------------------------------------------------------
   // Outputs, all registered
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         active_o <= 1'b0;
         stage_tristate_o <= 1'b1;
         sync_rect_en_o <= 1'b0;
         pfm_disable_o <= 1'b0;
         discharge_o <= 1'b0;
         ref_o <= 8'h00;
         target_level_o <= 6'h00;
      end
      else
      begin
         active_o <= (state == BES_SOFT || state == BES_RUN);
         stage_tristate_o <= !(state == BES_SOFT || state == BES_RUN);
         sync_rect_en_o <= (state == BES_RUN);
         pfm_disable_o <= sel_set[BES_SET_MODE_BIT];
         discharge_o <= ctrl[BES_CTRL_DIS_BIT] && (!en_q || !sw_en_sel);
         ref_o <= ref_lvl;
         target_level_o <= sel_set[BES_LVL_W-1:0];
      end
   end

   // Read data one cycle after strobe; nothing answers with the pin low
   always_ff @(posedge clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
         rdata_o <= 8'h00;
      else if (rd_i && en_q)
      begin
         case (addr_i)
            BES_ADDR_SET_A: rdata_o <= set_a;
            BES_ADDR_SET_B: rdata_o <= set_b;
            BES_ADDR_CTRL: rdata_o <= ctrl;
            BES_ADDR_STAT: rdata_o <= {6'h00, state};
            default: rdata_o <= 8'h00;
         endcase
      end
      else
         rdata_o <= 8'h00;
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   property p_off_when_low;
      @(posedge clk_i) disable iff (!rstn_i) !en_q |=> ##1 !active_o;
   endproperty
   a_off_when_low: assert property (p_off_when_low) else $error("active with enable low");

   property p_no_read_low;
      @(posedge clk_i) disable iff (!rstn_i) (rd_i && !en_q) |=> rdata_o == 8'h00;
   endproperty
   a_no_read_low: assert property (p_no_read_low) else $error("read answered with enable low");

   property p_no_write_low;
      @(posedge clk_i) disable iff (!rstn_i) (!en_q && !RESET_ON_LOW) |=> $stable(set_a) && $stable(ctrl);
   endproperty
   a_no_write_low: assert property (p_no_write_low) else $error("register changed with enable low");

   property p_discharge;
      @(posedge clk_i) disable iff (!rstn_i)
         (ctrl[BES_CTRL_DIS_BIT] && !sw_en_sel) |=> discharge_o;
   endproperty
   a_discharge: assert property (p_discharge) else $error("discharge missing");

   property p_start;
      @(posedge clk_i) disable iff (!rstn_i) (state == BES_OFF && want_on) |=> state == BES_SOFT;
   endproperty
   a_start: assert property (p_start) else $error("soft-start not entered");

   property p_ramp;
      @(posedge clk_i) disable iff (!rstn_i) (state == BES_SOFT) |=> ref_lvl - $past(ref_lvl) <= 8'h01;
   endproperty
   a_ramp: assert property (p_ramp) else $error("reference stepped too fast");

   property p_no_sr_soft;
      @(posedge clk_i) disable iff (!rstn_i) (state == BES_SOFT) |=> !sync_rect_en_o;
   endproperty
   a_no_sr_soft: assert property (p_no_sr_soft) else $error("rectification during soft-start");

   property p_fault;
      @(posedge clk_i) disable iff (!rstn_i)
         (state == BES_RUN && cl_cnt == 5'(BES_CL_LIMIT)) |=> ##1 stage_tristate_o;
   endproperty
   a_fault: assert property (p_fault) else $error("no tri-state after limit");

   property p_sel03;
      @(posedge clk_i) disable iff (!rstn_i)
         (SEL_TIED_LOW && $past(rstn_i)) |-> target_level_o == $past(set_a[5:0]);
   endproperty
   a_sel03: assert property (p_sel03) else $error("select not tied low");

   c_start: cover property (@(posedge clk_i) disable iff (!rstn_i) state == BES_SOFT ##1 state == BES_RUN);
   c_retry: cover property (@(posedge clk_i) disable iff (!rstn_i) state == BES_RETRY);
   c_disch: cover property (@(posedge clk_i) disable iff (!rstn_i) discharge_o);

endmodule
`default_nettype wire

/* verif/bes_host.sv */
// Host model: drives the enable and select pins and the modulator cycle flags
`timescale 1ns/1ps
`default_nettype none
module bes_host
(
   input wire logic clk_i,
   output logic enable_pin_o,
   output logic voltage_select_pin_o,
   output logic sw_cycle_o,
   output logic current_limit_o
);
   // Select held low from reset so the first setting is in force
   initial
   begin
      enable_pin_o = 1'b0;
      voltage_select_pin_o = 1'b0;
      sw_cycle_o = 1'b0;
      current_limit_o = 1'b0;
   end
   // Pin levels change just after an edge
   task automatic pins(input logic en, input logic sel);
   begin
      @(posedge clk_i);
      enable_pin_o <= en;
      voltage_select_pin_o <= sel;
   end
   endtask
   // Phases of 3 clocks so the synchroniser never misses an edge
   task automatic cycles(input int n, input logic lim);
   begin
      @(posedge clk_i);
      current_limit_o <= lim;
      repeat (n)
      begin
         repeat (3) @(posedge clk_i);
         sw_cycle_o <= 1'b1;
         repeat (3) @(posedge clk_i);
         sw_cycle_o <= 1'b0;
      end
      repeat (4) @(posedge clk_i);
      current_limit_o <= 1'b0;
   end
   endtask
endmodule
`default_nettype wire

/* verif/tb.sv */
// Self-checking bench for the regulator enable and soft-start controller
`timescale 1ns/1ps
`default_nettype none
module tb;
   import bes_pkg::*;
   logic clk_i, rstn_i, en, sel, swc, lim, wr_i, rd_i;
   logic [3:0] addr_i;
   logic [7:0] wdata_i, rdata_o, ref_o, d;
   logic act, tri_o, sr, pfm, dis;
   logic [5:0] lvl;
   logic [7:0] rd_b, rd_c, rd_d;
   logic [5:0] lvl_c;
   int fail_count = 0;
   int checks = 0;
   int cyc = 0;
   // ----------------------------------------
   // Clock, watchdog, design and host
   // ----------------------------------------
   initial
   begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end
   // A hang counts as a mismatch
   always @(posedge clk_i)
   begin
      cyc <= cyc + 1;
      if (cyc == 20000)
      begin
         fail_count = fail_count + 1;
         finish_test();
      end
   end
   bes_ctrl #(.BUILD_OPT(BES_OPT_00), .RETRY_CYC(50)) dut (.clk_i(clk_i), .rstn_i(rstn_i),
      .enable_pin_i(en), .voltage_select_pin_i(sel), .sw_cycle_i(swc), .current_limit_i(lim),
      .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
      .active_o(act), .stage_tristate_o(tri_o), .sync_rect_en_o(sr), .pfm_disable_o(pfm),
      .discharge_o(dis), .ref_o(ref_o), .target_level_o(lvl));
   bes_host host (.clk_i(clk_i), .enable_pin_o(en), .voltage_select_pin_o(sel),
      .sw_cycle_o(swc), .current_limit_o(lim));
   // Build variants share pins and bus; only defaults, select tie and low-enable reset differ
   bes_ctrl #(.BUILD_OPT(BES_OPT_01), .RETRY_CYC(50)) dut_b (.clk_i(clk_i), .rstn_i(rstn_i),
      .enable_pin_i(en), .voltage_select_pin_i(sel), .sw_cycle_i(swc), .current_limit_i(lim),
      .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rd_b),
      .active_o(), .stage_tristate_o(), .sync_rect_en_o(), .pfm_disable_o(),
      .discharge_o(), .ref_o(), .target_level_o());
   bes_ctrl #(.BUILD_OPT(BES_OPT_03), .RETRY_CYC(50)) dut_c (.clk_i(clk_i), .rstn_i(rstn_i),
      .enable_pin_i(en), .voltage_select_pin_i(sel), .sw_cycle_i(swc), .current_limit_i(lim),
      .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rd_c),
      .active_o(), .stage_tristate_o(), .sync_rect_en_o(), .pfm_disable_o(),
      .discharge_o(), .ref_o(), .target_level_o(lvl_c));
   bes_ctrl #(.BUILD_OPT(BES_OPT_04), .RETRY_CYC(50)) dut_d (.clk_i(clk_i), .rstn_i(rstn_i),
      .enable_pin_i(en), .voltage_select_pin_i(sel), .sw_cycle_i(swc), .current_limit_i(lim),
      .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rd_d),
      .active_o(), .stage_tristate_o(), .sync_rect_en_o(), .pfm_disable_o(),
      .discharge_o(), .ref_o(), .target_level_o());
   // ----------------------------------------
   // Access and compare tasks
   // ----------------------------------------
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
   begin
      checks = checks + 1;
      if (got !== exp)
      begin
         fail_count = fail_count + 1;
         $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
   end
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] v);
   begin
      @(posedge clk_i);
      addr_i <= a;
      wdata_i <= v;
      wr_i <= 1'b1;
      @(posedge clk_i);
      wr_i <= 1'b0;
   end
   endtask
   // Read data stand only in the cycle after the strobe
   task automatic rdc(input logic [3:0] a, input logic [7:0] exp);
   begin
      @(posedge clk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge clk_i);
      rd_i <= 1'b0;
      #1 chk(rdata_o, exp);
   end
   endtask
   task automatic tick(input int n);
   begin
      repeat (n) @(negedge clk_i);
   end
   endtask
   // Bounded wait for the end of soft-start
   task automatic wait_run();
   begin
      for (int i = 0; i < 5000 && sr !== 1'b1; i++) @(negedge clk_i);
   end
   endtask
   task automatic finish_test();
   begin
      if (fail_count == 0 && checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   end
   endtask
   // ----------------------------------------
   // Test sequence
   // ----------------------------------------
   initial
   begin
      rstn_i = 1'b0;
      wr_i = 1'b0;
      rd_i = 1'b0;
      addr_i = 4'h0;
      wdata_i = 8'h00;
      repeat (3) @(posedge clk_i);
      rstn_i <= 1'b1;
      tick(2);
      // Pin low: off, refused, discharging
      rdc(BES_ADDR_SET_A, 8'h00);
      chk({5'h0, act, tri_o, dis}, 8'h03);
      host.pins(1'b1, 1'b0);
      tick(10);
      chk({5'h0, act, sr, dis}, 8'h04);
      rdc(BES_ADDR_SET_A, {2'b10, BES_LVL_A_RST});
      rdc(BES_ADDR_SET_B, {2'b10, BES_LVL_B_RST});
      chk(rd_b, {2'b00, BES_LVL_B_RST});
      rdc(BES_ADDR_CTRL, BES_CTRL_RST);
      rdc(BES_ADDR_STAT, {6'h0, BES_SOFT});
      rdc(4'hF, 8'h00);
      tick(100);
      chk({7'h0, ref_o > 8'h00 && ref_o < 8'h10}, 8'h01);
      wait_run();
      chk(ref_o, BES_REF_MAX);
      rdc(BES_ADDR_STAT, {6'h0, BES_RUN});
      chk({1'b0, pfm, lvl}, {2'b00, BES_LVL_A_RST});
      host.pins(1'b1, 1'b1);
      tick(8);
      chk({2'b00, lvl}, {2'b00, BES_LVL_B_RST});
      chk({2'b00, lvl_c}, {2'b00, BES_LVL_A_RST});
      wr(BES_ADDR_SET_B, {2'b11, BES_LVL_B_RST});
      tick(3);
      chk({7'h0, pfm}, 8'h01);
      wr(BES_ADDR_SET_B, {2'b01, BES_LVL_B_RST});
      tick(3);
      chk({6'h0, act, dis}, 8'h01);
      host.pins(1'b1, 1'b0);
      tick(8);
      chk({6'h0, act, dis}, 8'h02);
      wait_run();
      // Fifteen limited cycles are not enough
      host.cycles(15, 1'b1);
      host.cycles(1, 1'b0);
      rdc(BES_ADDR_STAT, {6'h0, BES_RUN});
      host.cycles(16, 1'b1);
      // Last cycle end needs the synchroniser, the counter and the state before the outputs move
      tick(4);
      chk({6'h0, act, tri_o}, 8'h01);
      rdc(BES_ADDR_STAT, {6'h0, BES_RETRY});
      tick(20);
      chk({7'h0, tri_o}, 8'h01);
      for (int i = 0; i < 100 && act !== 1'b1; i++) @(negedge clk_i);
      rdc(BES_ADDR_STAT, {6'h0, BES_SOFT});
      // Values kept over pin low; discharge off when its bit is clear
      wr(BES_ADDR_SET_A, 8'h81);
      wr(BES_ADDR_CTRL, 8'h00);
      host.pins(1'b0, 1'b0);
      tick(8);
      chk({5'h0, act, tri_o, dis}, 8'h02);
      wr(BES_ADDR_SET_A, 8'h00);
      rdc(BES_ADDR_SET_A, 8'h00);
      host.pins(1'b1, 1'b0);
      tick(8);
      rdc(BES_ADDR_SET_A, 8'h81);
      chk(rd_d, {2'b10, BES_LVL_A_RST});
      finish_test();
   end
endmodule
`default_nettype wire
